// File: src/led_ctrl_regs.svh
// Register offsets, field positions, reset values and timing counts of the LED control bank
`ifndef LED_CTRL_REGS_SVH
`define LED_CTRL_REGS_SVH
`define ADDR_ENGINE_CONTROL   8'h00
`define ADDR_CHANNEL_MODE     8'h01
`define ADDR_RED_DUTY         8'h02
`define ADDR_GREEN_DUTY       8'h03
`define ADDR_BLUE_DUTY        8'h04
`define ADDR_RED_CURRENT      8'h05
`define ADDR_GREEN_CURRENT    8'h06
`define ADDR_BLUE_CURRENT     8'h07
`define BIT_LOG_SELECT        7
`define BIT_POWER_UP          6
`define RST_ENGINE_CONTROL    8'h00
`define RST_CHANNEL_MODE      8'h00
`define RST_DUTY              8'h00
`define RST_CURRENT           8'hAF
`define CLK_PERIOD_NS         10
`define STARTUP_TIME_US       500
`define STARTUP_CYCLES        ((`STARTUP_TIME_US * 1000) / `CLK_PERIOD_NS)
`define SLOW_DIV_CYCLES       3052
`endif

// File: src/led_ctrl_pkg.sv
// Types shared by the LED control bank
package led_ctrl_pkg;
  typedef enum logic [1:0] {
    EXEC_HOLD = 2'b00,
    EXEC_STEP = 2'b01,
    EXEC_RUN  = 2'b10,
    EXEC_ONCE = 2'b11
  } exec_code_t;
  typedef enum logic [1:0] {
    MODE_OFF    = 2'b00,
    MODE_LOAD   = 2'b01,
    MODE_RUN    = 2'b10,
    MODE_DIRECT = 2'b11
  } channel_mode_select_t;
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_BUSY = 2'b01,
    ENG_DONE = 2'b10
  } eng_state_t;
endpackage

// File: src/engine_link_if.sv
// Signals between the register bank and one channel engine sequencer
`timescale 1ns/1ns
interface engine_link_if;
  import led_ctrl_pkg::*;
  exec_code_t exec_code;
  channel_mode_select_t   channel_mode_select;
  logic       slow_tick;
  logic       end_seen;
  logic       clear_exec;
  logic [3:0] prog_count;
  logic       busy;
  modport bank (output exec_code, output channel_mode_select, output slow_tick, output end_seen,
                input clear_exec, input prog_count, input busy);
  modport engine (input exec_code, input channel_mode_select, input slow_tick, input end_seen,
                  output clear_exec, output prog_count, output busy);
endinterface

// File: src/channel_engine.sv
// Per-channel execution sequencer: steps, runs or holds the program counter
`timescale 1ns/1ns
module channel_engine
  import led_ctrl_pkg::*;
#(
  parameter int CMD_TICKS = 16
) (
  input wire logic      clk,
  input wire logic      rst,
  engine_link_if.engine lnk
);
  // The tick counter is 8 bits wide
  if (CMD_TICKS < 1 || CMD_TICKS > 255) begin : g_bad_ticks
    $error("CMD_TICKS out of range");
  end

  typedef struct packed {
    eng_state_t st;
    logic [7:0] ticks;
    logic [3:0] pc;
    logic       incr;
    logic       clr;
  } eng_t;

  eng_t s_reg;
  eng_t s_next;

  // Sequencing of one command per 16 slow ticks
  always_comb begin
    s_next = s_reg;
    s_next.clr = 1'b0;
    case (s_reg.st)
      ENG_IDLE: begin
        if (lnk.channel_mode_select == MODE_LOAD) begin
          s_next.pc = 4'h0;
        // The bank clears its field one cycle after clr, so a clr cycle must not restart
        end else if (lnk.channel_mode_select == MODE_RUN && lnk.exec_code != EXEC_HOLD
                     && !s_reg.clr) begin
          s_next.st = ENG_BUSY;
          s_next.ticks = 8'h00;
          s_next.incr = (lnk.exec_code != EXEC_ONCE);
        end
      end
      ENG_BUSY: begin
        if (lnk.slow_tick) begin
          s_next.ticks = s_reg.ticks + 8'h01;
          if (s_reg.ticks == 8'(CMD_TICKS - 1)) begin
            s_next.st = ENG_DONE;
          end
        end
      end
      ENG_DONE: begin
        // The command in progress always completes before holding
        s_next.st = ENG_IDLE;
        if (lnk.end_seen) begin
          s_next.pc = 4'h0;
          s_next.clr = 1'b1;
        end else begin
          if (s_reg.incr) begin
            s_next.pc = s_reg.pc + 4'h1;
          end
          s_next.clr = (lnk.exec_code == EXEC_STEP) || (lnk.exec_code == EXEC_ONCE);
        end
      end
      default: begin
        s_next.st = ENG_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '{st: ENG_IDLE, ticks: 8'h00, pc: 4'h0, incr: 1'b0, clr: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign lnk.clear_exec = s_reg.clr;
  assign lnk.prog_count = s_reg.pc;
  assign lnk.busy       = (s_reg.st != ENG_IDLE);

  once_keeps_pc_a: assert property (@(posedge clk) disable iff (rst)
    (s_reg.st == ENG_DONE && !s_reg.incr) |=> (s_reg.pc == $past(s_reg.pc)) || $past(lnk.end_seen))
    else $error("execute-once moved the program counter");
  load_clears_pc_a: assert property (@(posedge clk) disable iff (rst)
    (s_reg.st == ENG_IDLE && lnk.channel_mode_select == MODE_LOAD) |=> (s_reg.pc == 4'h0))
    else $error("load mode did not clear the program counter");
  hold_stays_idle_a: assert property (@(posedge clk) disable iff (rst)
    (s_reg.st == ENG_IDLE && lnk.exec_code == EXEC_HOLD) |=> (s_reg.st == ENG_IDLE))
    else $error("engine started while on hold");
  end_clears_a: assert property (@(posedge clk) disable iff (rst)
    (s_reg.st == ENG_DONE && lnk.end_seen)
    |=> (s_reg.pc == 4'h0) && s_reg.clr)
    else $error("end of program left the counter set");
  step_advances_a: assert property (@(posedge clk) disable iff (rst)
    (s_reg.st == ENG_DONE && s_reg.incr && !lnk.end_seen)
    |=> s_reg.pc == $past(s_reg.pc) + 4'h1)
    else $error("program counter did not advance");
  no_restart_a: assert property (@(posedge clk) disable iff (rst)
    s_reg.clr
    |=> s_reg.st == ENG_IDLE)
    else $error("engine restarted on a stale execution code");
endmodule

// File: src/led_channel_control_regs.sv
// Control register bank of the three-channel LED driver
`timescale 1ns/1ns
`include "led_ctrl_regs.svh"

// Summary of operation
// - Log select in engine control bit 7 maps duty values onto a logarithmic scale.
// - Setting power-up bit 6 starts a startup sequence that ends about 500 us later.
// - A low external enable pin forces the power-up bit back to zero.
// - Execution fields sit at bits 5:4 red, 3:2 green and 1:0 blue of engine control.
// - Hold finishes the command in progress and then stays stopped.
// - Step executes one instruction, increments the counter and returns to hold.
// - Run executes continuously from the current program counter.
// - Execute-once runs one instruction without incrementing, then returns to hold.
// - Execution fields follow the 32 kHz clock; host writes are spaced over 488 us.
// - Mode fields sit at bits 5:4, 3:2, 1:0; code 00 disables the channel.
// - Mode 01 allows program loading and clears the channel program counter.
// - Mode 10 runs the channel program as its execution field says.
// - Mode 11 drives the channel duty from its 8-bit duty register.
// - Mode fields follow the 32 kHz clock; host writes are spaced over 153 us.
// - The 8-bit current code sets 0.1 mA per step up to 25.5 mA, reset 17.5 mA.
// - An end-of-program instruction clears the counter and sets execution to hold.
module led_channel_control_regs
  import led_ctrl_pkg::*;
#(
  parameter int STARTUP_CYCLES = `STARTUP_CYCLES,
  parameter int SLOW_DIV       = `SLOW_DIV_CYCLES
) (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  // Register access from the serial interface
  input  wire logic       WR_EN,
  input  wire logic       RD_EN,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  output logic [7:0]      RDATA,
  // External pins
  input  wire logic       ENABLE_PIN,
  input  wire logic [2:0] END_SEEN,
  // Channel outputs
  output logic            READY,
  output logic            LOG_SCALE,
  output logic [23:0]     DUTY,
  output logic [23:0]     CURRENT,
  output logic [2:0]      CH_ENABLE,
  output logic [2:0]      ENGINE_BUSY,
  output logic [11:0]     PROG_COUNT
);
  // Counters are 20 and 16 bits; a startup under 8 cycles would trip the early-finish check
  if (STARTUP_CYCLES < 8 || STARTUP_CYCLES > 1048575) begin : g_bad_startup
    $error("STARTUP_CYCLES out of range");
  end
  if (SLOW_DIV < 2 || SLOW_DIV > 65535) begin : g_bad_div
    $error("SLOW_DIV out of range");
  end

  typedef struct packed {
    logic [1:0]  en_sync;
    logic [7:0]  ctrl;
    logic [7:0]  mode;
    logic [5:0]  exec_slow;
    logic [5:0]  mode_slow;
    logic [23:0] duty;
    logic [23:0] current;
    logic [19:0] start_cnt;
    logic        ready;
    logic [15:0] div_cnt;
    logic        tick;
    logic [7:0]  rdata;
    logic [23:0] duty_out;
    logic [2:0]  ch_en;
    logic [2:0]  busy;
    logic [11:0] pc;
  } bank_t;

  bank_t r_reg;
  bank_t r_next;

  engine_link_if lnk0 ();
  engine_link_if lnk1 ();
  engine_link_if lnk2 ();

  // Logarithmic brightness map: roughly 2^(v/32) scaled onto 0..255
  function automatic logic [7:0] log_map(input logic [7:0] v);
    logic [15:0] m;
    logic [2:0]  e;
    m = 16'h0000;
    e = v[7:5];
    if (v == 8'h00) begin
      m = 16'h0000;
    end else begin
      m = ({11'h000, 1'b1, v[4:1]} << e) >> 4'h4;
    end
    return (m[15:8] != 8'h00) ? 8'hFF : m[7:0];
  endfunction

  // Field of a channel from its channel index: red is field 2, blue is field 0
  function automatic logic [1:0] fld(input logic [5:0] r, input int ch);
    return r[2*ch +: 2];
  endfunction

  // Host engine control write, with hardware hold-back from the engines
  always_comb begin
    logic [2:0] clr;
    clr = {lnk2.clear_exec, lnk1.clear_exec, lnk0.clear_exec};
    r_next = r_reg;
    r_next.en_sync = {r_reg.en_sync[0], ENABLE_PIN};
    // Slow tick approximates the 32 kHz clock the fields are resynchronised to
    r_next.tick = 1'b0;
    if (r_reg.div_cnt == 16'(SLOW_DIV - 1)) begin
      r_next.div_cnt = 16'h0000;
      r_next.tick = 1'b1;
    end else begin
      r_next.div_cnt = r_reg.div_cnt + 16'h0001;
    end
    if (WR_EN) begin
      case (ADDR)
        `ADDR_ENGINE_CONTROL: r_next.ctrl = WDATA;
        `ADDR_CHANNEL_MODE:   r_next.mode = {2'b00, WDATA[5:0]};
        `ADDR_RED_DUTY:       r_next.duty[23:16] = WDATA;
        `ADDR_GREEN_DUTY:     r_next.duty[15:8] = WDATA;
        `ADDR_BLUE_DUTY:      r_next.duty[7:0] = WDATA;
        `ADDR_RED_CURRENT:    r_next.current[23:16] = WDATA;
        `ADDR_GREEN_CURRENT:  r_next.current[15:8] = WDATA;
        `ADDR_BLUE_CURRENT:   r_next.current[7:0] = WDATA;
        default: begin
        end
      endcase
    end
    // Engine return-to-hold beats a host write in the same cycle
    for (int c = 0; c < 3; c++) begin
      if (clr[c]) begin
        r_next.ctrl[2*c +: 2] = EXEC_HOLD;
        r_next.exec_slow[2*c +: 2] = EXEC_HOLD;
      end
    end
    // Pin low wins over any write of the power-up bit
    if (!r_reg.en_sync[1]) begin
      r_next.ctrl[`BIT_POWER_UP] = 1'b0;
    end
    // Resynchronise fields only on the slow tick
    if (r_reg.tick) begin
      r_next.exec_slow = r_next.ctrl[5:0];
      r_next.mode_slow = r_reg.mode[5:0];
    end
    // Startup delay counted from the power-up bit
    if (!r_reg.ctrl[`BIT_POWER_UP]) begin
      r_next.start_cnt = 20'h00000;
      r_next.ready = 1'b0;
    end else if (!r_reg.ready) begin
      if (r_reg.start_cnt == 20'(STARTUP_CYCLES - 1)) begin
        r_next.ready = 1'b1;
      end else begin
        r_next.start_cnt = r_reg.start_cnt + 20'h00001;
      end
    end
    // Read data
    r_next.rdata = r_reg.rdata;
    if (RD_EN) begin
      case (ADDR)
        `ADDR_ENGINE_CONTROL: r_next.rdata = r_reg.ctrl;
        `ADDR_CHANNEL_MODE:   r_next.rdata = r_reg.mode;
        `ADDR_RED_DUTY:       r_next.rdata = r_reg.duty[23:16];
        `ADDR_GREEN_DUTY:     r_next.rdata = r_reg.duty[15:8];
        `ADDR_BLUE_DUTY:      r_next.rdata = r_reg.duty[7:0];
        `ADDR_RED_CURRENT:    r_next.rdata = r_reg.current[23:16];
        `ADDR_GREEN_CURRENT:  r_next.rdata = r_reg.current[15:8];
        `ADDR_BLUE_CURRENT:   r_next.rdata = r_reg.current[7:0];
        default:              r_next.rdata = 8'h00;
      endcase
    end
    // Output duty and channel enables
    for (int c = 0; c < 3; c++) begin
      logic [7:0] d;
      d = r_reg.duty[8*c +: 8];
      if (r_reg.ctrl[`BIT_LOG_SELECT]) begin
        d = log_map(d);
      end
      r_next.ch_en[c] = r_reg.ready && (fld(r_reg.mode_slow, c) != MODE_OFF);
      r_next.duty_out[8*c +: 8] =
        (r_reg.ready && fld(r_reg.mode_slow, c) == MODE_DIRECT) ? d : 8'h00;
    end
    // Engine status mirrors, registered so the outputs come from flip-flops
    r_next.busy = {lnk2.busy, lnk1.busy, lnk0.busy};
    r_next.pc   = {lnk2.prog_count, lnk1.prog_count, lnk0.prog_count};
  end

  // State register
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      r_reg <= '0;
      r_reg.ctrl <= `RST_ENGINE_CONTROL;
      r_reg.mode <= `RST_CHANNEL_MODE;
      r_reg.duty <= {3{`RST_DUTY}};
      r_reg.current <= {3{`RST_CURRENT}};
    end else begin
      r_reg <= r_next;
    end
  end

  // Engine links see the resynchronised fields; engines stall until startup is done
  assign lnk0.exec_code = exec_code_t'(r_reg.ready ? r_reg.exec_slow[1:0] : 2'b00);
  assign lnk1.exec_code = exec_code_t'(r_reg.ready ? r_reg.exec_slow[3:2] : 2'b00);
  assign lnk2.exec_code = exec_code_t'(r_reg.ready ? r_reg.exec_slow[5:4] : 2'b00);
  assign lnk0.channel_mode_select   = channel_mode_select_t'(r_reg.mode_slow[1:0]);
  assign lnk1.channel_mode_select   = channel_mode_select_t'(r_reg.mode_slow[3:2]);
  assign lnk2.channel_mode_select   = channel_mode_select_t'(r_reg.mode_slow[5:4]);
  assign lnk0.slow_tick = r_reg.tick;
  assign lnk1.slow_tick = r_reg.tick;
  assign lnk2.slow_tick = r_reg.tick;
  assign lnk0.end_seen  = END_SEEN[0];
  assign lnk1.end_seen  = END_SEEN[1];
  assign lnk2.end_seen  = END_SEEN[2];

  channel_engine u_eng0 (.clk(CLK), .rst(SYS_RST), .lnk(lnk0));
  channel_engine u_eng1 (.clk(CLK), .rst(SYS_RST), .lnk(lnk1));
  channel_engine u_eng2 (.clk(CLK), .rst(SYS_RST), .lnk(lnk2));

  // Outputs straight from the state register
  assign RDATA       = r_reg.rdata;
  assign READY       = r_reg.ready;
  assign LOG_SCALE   = r_reg.ctrl[`BIT_LOG_SELECT];
  assign DUTY        = r_reg.duty_out;
  assign CURRENT     = r_reg.current;
  assign CH_ENABLE   = r_reg.ch_en;
  assign ENGINE_BUSY = r_reg.busy;
  assign PROG_COUNT  = r_reg.pc;

  pin_low_clears_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !r_reg.en_sync[1] |=> !r_reg.ctrl[`BIT_POWER_UP])
    else $error("power-up bit survived a low enable pin");
  startup_not_early_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    $rose(r_reg.ctrl[`BIT_POWER_UP]) |-> !r_reg.ready [*8])
    else $error("startup finished too early");
  startup_done_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (r_reg.ctrl[`BIT_POWER_UP] && r_reg.start_cnt == 20'(STARTUP_CYCLES - 1) && !r_reg.ready)
    |=> r_reg.ready || !r_reg.ctrl[`BIT_POWER_UP])
    else $error("startup did not finish on time");
  direct_duty_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (r_reg.ready && r_reg.mode_slow[5:4] == 2'b11 && !r_reg.ctrl[`BIT_LOG_SELECT])
    |=> r_reg.duty_out[23:16] == $past(r_reg.duty[23:16]))
    else $error("direct duty not forwarded");
  log_applied_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (r_reg.ready && r_reg.mode_slow[1:0] == 2'b11 && r_reg.ctrl[`BIT_LOG_SELECT])
    |=> r_reg.duty_out[7:0] == log_map($past(r_reg.duty[7:0])))
    else $error("log map not applied");
  mode_sync_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !r_reg.tick |=> $stable(r_reg.mode_slow))
    else $error("mode field moved off the slow tick");
  exec_clear_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    lnk2.clear_exec |=> r_reg.ctrl[5:4] == 2'b00)
    else $error("execution field not returned to hold");
  current_reset_a: assert property (@(posedge CLK)
    $past(SYS_RST) |-> r_reg.current == {3{`RST_CURRENT}})
    else $error("current code reset wrong");

  // Register writes land as addressed unless the pin or an engine overrides them
  ctrl_write_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (WR_EN && ADDR == `ADDR_ENGINE_CONTROL && r_reg.en_sync[1] && !lnk0.clear_exec
     && !lnk1.clear_exec && !lnk2.clear_exec)
    |=> r_reg.ctrl == $past(WDATA))
    else $error("engine control write lost");
  mode_write_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (WR_EN && ADDR == `ADDR_CHANNEL_MODE)
    |=> r_reg.mode == {2'b00, $past(WDATA[5:0])})
    else $error("mode write lost");
  duty_write_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (WR_EN && ADDR == `ADDR_BLUE_DUTY)
    |=> r_reg.duty[7:0] == $past(WDATA))
    else $error("duty write lost");
  current_write_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (WR_EN && ADDR == `ADDR_RED_CURRENT)
    |=> r_reg.current[23:16] == $past(WDATA))
    else $error("current write lost");
  duty_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !WR_EN
    |=> $stable(r_reg.duty))
    else $error("duty register moved without a write");
  current_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !WR_EN
    |=> $stable(r_reg.current))
    else $error("current code moved without a write");

  // Read data is registered and stands until the next read
  read_ctrl_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (RD_EN && ADDR == `ADDR_ENGINE_CONTROL)
    |=> r_reg.rdata == $past(r_reg.ctrl))
    else $error("engine control read back wrong");
  read_unmapped_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (RD_EN && ADDR > `ADDR_BLUE_CURRENT)
    |=> r_reg.rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_stands_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !RD_EN
    |=> $stable(r_reg.rdata))
    else $error("read data moved without a read");

  // Startup counting, and the channels stay dark until it ends
  ready_drops_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !r_reg.ctrl[`BIT_POWER_UP]
    |=> !r_reg.ready)
    else $error("ready stayed up without power");
  startup_count_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (r_reg.ctrl[`BIT_POWER_UP] && !r_reg.ready && r_reg.start_cnt != 20'(STARTUP_CYCLES - 1))
    |=> r_reg.start_cnt == $past(r_reg.start_cnt) + 20'h00001)
    else $error("startup counter skipped");
  stall_unready_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !r_reg.ready
    |=> (r_reg.ch_en == 3'b000) && (r_reg.duty_out == 24'h000000))
    else $error("channel active before startup ended");

  // Channel outputs follow the resynchronised mode fields
  off_disables_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (r_reg.mode_slow[5:4] == 2'b00)
    |=> !r_reg.ch_en[2])
    else $error("disabled channel still enabled");
  duty_off_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (r_reg.mode_slow[3:2] != 2'b11)
    |=> r_reg.duty_out[15:8] == 8'h00)
    else $error("duty shown outside direct control");
  log_off_linear_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (r_reg.ready && r_reg.mode_slow[1:0] == 2'b11 && !r_reg.ctrl[`BIT_LOG_SELECT])
    |=> r_reg.duty_out[7:0] == $past(r_reg.duty[7:0]))
    else $error("linear duty not forwarded");

  // Execution fields move only on the slow tick or on an engine's return to hold
  exec_sync_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!r_reg.tick && !lnk0.clear_exec && !lnk1.clear_exec && !lnk2.clear_exec)
    |=> $stable(r_reg.exec_slow))
    else $error("execution field moved off the slow tick");
  exec_clear_green_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    lnk1.clear_exec
    |=> r_reg.ctrl[3:2] == 2'b00)
    else $error("green execution field not returned to hold");
  exec_clear_blue_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    lnk0.clear_exec
    |=> r_reg.ctrl[1:0] == 2'b00)
    else $error("blue execution field not returned to hold");
endmodule

// File: sim/led_host_model.sv
// Host processor model that drives the register strobes of the LED control bank
`timescale 1ns/1ns
module led_host_model #(
  parameter int SLOW_DIV = 4
) (
  // Clock
  input  wire logic       clk,
  // Register strobes toward the bank
  output logic            wr_en,
  output logic            rd_en,
  output logic [7:0]      addr,
  output logic [7:0]      wdata,
  input  wire logic [7:0] rdata
);
  // Gaps cover 16 and 5 slow ticks plus margin, else the resync drops a write
  localparam int CTRL_GAP = 16 * SLOW_DIV + 16;
  localparam int MODE_GAP = 5 * SLOW_DIV + 8;
  int cyc       = 0;
  int last_ctrl = -1000;
  int last_mode = -1000;

  // Idle strobes from time zero; program counters are never touched here
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 8'h00;
    wdata = 8'h00;
  end

  // Cycle count used for write spacing
  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  // One write; control and mode writes first wait out their gap
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    while ((a === 8'h00 && cyc - last_ctrl < CTRL_GAP) ||
           (a === 8'h01 && cyc - last_mode < MODE_GAP)) begin
      @(posedge clk);
    end
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    if (a === 8'h00) last_ctrl = cyc;
    if (a === 8'h01) last_mode = cyc;
  endtask

  // One read; data is taken after the registered answer has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    #1 d = rdata;
  endtask
endmodule

// File: sim/led_channel_control_regs_tb_top.sv
// Self-checking bench for the LED control register bank
`timescale 1ns/1ns
`include "led_ctrl_regs.svh"
module led_channel_control_regs_tb_top;
  import led_ctrl_pkg::*;
  // Short counts keep the run brief
  localparam int STARTUP = 20;
  localparam int SDIV    = 4;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        wr_en, rd_en, enable_pin = 1'b1;
  logic [7:0]  addr, wdata, rdata, rv;
  logic [2:0]  end_seen = 3'h0;
  logic        ready, log_scale;
  logic [23:0] duty, current;
  logic [2:0]  ch_enable, engine_busy;
  logic [11:0] prog_count;
  int          mismatches = 0;
  int          num_checks = 0;

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  led_channel_control_regs #(.STARTUP_CYCLES(STARTUP), .SLOW_DIV(SDIV)) u_led_channel_control_regs (
    .CLK(clk), .SYS_RST(sys_rst), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr), .WDATA(wdata),
    .RDATA(rdata), .ENABLE_PIN(enable_pin), .END_SEEN(end_seen), .READY(ready),
    .LOG_SCALE(log_scale), .DUTY(duty), .CURRENT(current), .CH_ENABLE(ch_enable),
    .ENGINE_BUSY(engine_busy), .PROG_COUNT(prog_count));

  led_host_model #(.SLOW_DIV(SDIV)) u_led_host_model (
    .clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    u_led_host_model.rd(a, rv);
    chk(rv, exp);
  endtask

  // Let edge updates land before looking
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic logic probe(input int sel);
    case (sel)
      0, 1, 2: probe = engine_busy[sel];
      3:       probe = ready;
      4:       probe = (prog_count[7:4] === 4'h1);
      default: probe = (prog_count[7:4] === 4'h0);
    endcase
  endfunction

  // Bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_until(input int sel, input logic v, input int bound);
    int n;
    n = 0;
    while (probe(sel) !== v) begin
      settle(1);
      n++;
      if (n > bound) begin
        chk(probe(sel), v);
        wrap_up();
      end
    end
  endtask

  // Distinct per-address pattern
  function automatic logic [7:0] dv(input int a);
    dv = {a[3:0], ~a[3:0]};
  endfunction

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    u_led_host_model.wr(8'h08, 8'hFF);
    for (int a = 0; a < 9; a++) rd_chk(a[7:0], (a >= 5 && a <= 7) ? `RST_CURRENT : 8'h00);
    chk(current, 24'hAFAFAF);
    for (int a = 2; a < 8; a++) u_led_host_model.wr(a[7:0], dv(a));
    for (int a = 2; a < 8; a++) rd_chk(a[7:0], dv(a));
    chk(current, {dv(5), dv(6), dv(7)});
    u_led_host_model.wr(8'h01, 8'hFF);
    rd_chk(8'h01, 8'h3F);
    // Power-up delay, then direct control on all channels
    u_led_host_model.wr(8'h00, 8'h40);
    settle(STARTUP / 2);
    chk(ready, 1'b0);
    wait_until(3, 1'b1, STARTUP + 20);
    settle(8 * SDIV);
    chk(duty, {dv(2), dv(3), dv(4)});
    chk(ch_enable, 3'b111);
    // Red step advances the counter and falls back to hold
    u_led_host_model.wr(8'h01, 8'h20);
    u_led_host_model.wr(8'h00, 8'h50);
    wait_until(2, 1'b1, 200);
    wait_until(2, 1'b0, 200);
    settle(2 * SDIV);
    chk(prog_count[11:8], 4'h1);
    rd_chk(8'h00, 8'h40);
    // Red execute-once leaves the counter alone
    u_led_host_model.wr(8'h00, 8'h70);
    wait_until(2, 1'b1, 200);
    wait_until(2, 1'b0, 200);
    settle(2 * SDIV);
    chk(prog_count[11:8], 4'h1);
    rd_chk(8'h00, 8'h40);
    // Green run keeps going until an end command
    u_led_host_model.wr(8'h01, 8'h28);
    u_led_host_model.wr(8'h00, 8'h48);
    wait_until(4, 1'b1, 300);
    rd_chk(8'h00, 8'h48);
    @(posedge clk);
    end_seen <= 3'b010;
    wait_until(5, 1'b1, 400);
    @(posedge clk);
    end_seen <= 3'b000;
    rd_chk(8'h00, 8'h40);
    // Blue run put on hold mid-command finishes and then stops
    u_led_host_model.wr(8'h01, 8'h2A);
    u_led_host_model.wr(8'h00, 8'h42);
    wait_until(0, 1'b1, 200);
    u_led_host_model.wr(8'h00, 8'h40);
    wait_until(0, 1'b0, 200);
    settle(100);
    chk(engine_busy, 3'b000);
    // Load mode clears the counter; disabled channels drop out
    u_led_host_model.wr(8'h01, 8'h10);
    settle(10 * SDIV);
    chk(prog_count[11:8], 4'h0);
    chk(ch_enable, 3'b100);
    // Log select reaches its output
    u_led_host_model.wr(8'h00, 8'hC0);
    settle(4);
    chk(log_scale, 1'b1);
    // Blue in direct control: the curve turns duty 0x4B into 0x05, far below linear
    u_led_host_model.wr(8'h01, 8'h03);
    settle(3 * SDIV);
    chk(duty, 24'h000005);
    // External enable low clears power-up
    @(posedge clk);
    enable_pin <= 1'b0;
    settle(6);
    rd_chk(8'h00, 8'h80);
    settle(2);
    chk(ready, 1'b0);
    chk(duty, 24'h000000);
    wrap_up();
  end
endmodule
